// file: sbrg_consts.svh
// offsets, field positions, reset values and divider counts of the rate generator
// assumes byte-wide registers reached over a plain strobe port
`ifndef SBRG_CONSTS_SVH
`define SBRG_CONSTS_SVH

// register offsets on the plain port
`define SBRG_ADDR_BAUD   3'h0
`define SBRG_ADDR_RXSC   3'h1
`define SBRG_ADDR_DLO    3'h2
`define SBRG_ADDR_DHI    3'h3
`define SBRG_ADDR_TXSC   3'h4

// field positions
`define SBRG_BIT_IDLE    6
`define SBRG_BIT_WIDE    3
`define SBRG_BIT_SYNC    4
`define SBRG_BIT_FAST    2
`define SBRG_BIT_TRMT    1
`define SBRG_BIT_SPEN    7

// writable bits of each control register
`define SBRG_MASK_BAUD   8'h1b
`define SBRG_MASK_RXSC   8'hf8
`define SBRG_MASK_TXSC   8'hfd

// reset values
`define SBRG_RST_BYTE    8'h00
`define SBRG_RST_IDLE    1'b1

// prescaler reload values, one less than the divide ratio
`define SBRG_PRE4        6'h03
`define SBRG_PRE16       6'h0f
`define SBRG_PRE64       6'h3f

// divide ratios as period multipliers
`define SBRG_MULT4       24'h000004
`define SBRG_MULT16      24'h000010
`define SBRG_MULT64      24'h000040

`endif

// file: sbrg_pkg.sv
// types and shared decoding of the serial rate generator
// assumes sbrg_consts.svh is on the include path
`include "sbrg_consts.svh"

package sbrg_pkg;

    // prescale ratio ahead of the divisor timer
    typedef enum logic [1:0] {
        SBRG_DIV4,
        SBRG_DIV16,
        SBRG_DIV64
    } sbrg_div_t;

    // mode bits handed to the transmitter and receiver
    typedef struct packed {
        logic port_en;
        logic sync_mode;
        logic wide;
        logic high_speed;
    } sbrg_cfg_t;

    // receiver events and status bits
    typedef struct packed {
        logic start;
        logic done;
        logic ferr;
        logic oerr;
        logic rx9d;
    } sbrg_rxst_t;

    // ratio chosen by mode, counter width and speed
    function automatic sbrg_div_t sbrg_div_select(input logic sync_m, input logic wide,
                                                  input logic fast);
        if (sync_m || (wide && fast))
            return SBRG_DIV4;
        else if (wide || fast)
            return SBRG_DIV16;
        return SBRG_DIV64;
    endfunction

    // whole clock period of one rate tick
    function automatic logic [23:0] sbrg_period(input sbrg_div_t sel, input logic [15:0] n);
        logic [23:0] m;
        m = (sel == SBRG_DIV4) ? `SBRG_MULT4 : (sel == SBRG_DIV16) ? `SBRG_MULT16 : `SBRG_MULT64;
        return 24'(m * ({8'h00, n} + 24'h000001));
    endfunction

endpackage

// file: sbrg_prescale.sv
// prescaler ahead of the divisor timer: one pulse every 4, 16 or 64 clocks
// assumes clr comes from logic on clk; ce freezes the count
`timescale 1ns/1ns
`include "sbrg_consts.svh"

module sbrg_prescale import sbrg_pkg::*; #(
    parameter int CW = 6
) (
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      ce,
    // control
    input  wire logic      clr,
    input  wire sbrg_div_t sel,
    // prescaled pulse
    output logic           pre_tick
);

    logic [CW-1:0] cnt;
    logic [CW-1:0] reload;

    // reload value for the selected ratio
    always_comb begin
        unique case (sel)
            SBRG_DIV4:  reload = CW'(`SBRG_PRE4);
            SBRG_DIV16: reload = CW'(`SBRG_PRE16);
            SBRG_DIV64: reload = CW'(`SBRG_PRE64);
            default:    reload = CW'(`SBRG_PRE64);
        endcase
    end

    // down counter; clearing loads a full prescale period, not a short one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (ce) begin
            if (clr || cnt == '0)
                cnt <= reload;
            else
                cnt <= cnt - 1'b1;
        end
    end

    assign pre_tick = ce && !clr && cnt == '0;

endmodule

// file: sbrg_top.sv
// serial rate generator: control registers, divisor timer and receive-idle flag
// assumes receiver and transmitter run on clk; the bus master keeps one-cycle strobes
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "sbrg_consts.svh"

////////////////////////////////////////////////////////////////////////////////

// How it works
// - dedicated rate timer, 8 or 16 bits wide, serves async and sync modes
// - timer starts in 8-bit mode; wide select switches to 16 bits
// - divisor n comes from high and low registers as one pair in 16-bit mode, from low alone in 8-bit mode
// - async multiplier chosen by high-speed and wide selects together
// - sync mode ignores the high-speed select
// - async, narrow, low speed: rate is clock over 64(n+1)
// - async, wide, low speed: rate is clock over 16(n+1)
// - sync mode, any width: rate is clock over 4(n+1)
// - writing either divisor register restarts the timer at once
// - receive-idle reads 1 when idle, 0 from start bit to character end
module sbrg_top import sbrg_pkg::*; (
    // clock, reset and freeze
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rd_data,
    // receiver and transmitter status
    input  wire sbrg_rxst_t rx_stat,
    input  wire logic       tx_shift_empty,
    // rate tick and modes
    output logic            baud_tick,
    output sbrg_cfg_t       cfg
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0]  baud_w;
    logic [7:0]  rxsc_w;
    logic [7:0]  txsc_w;
    logic [7:0]  div_lo;
    logic [7:0]  div_hi;
    logic        rcv_idle;
    logic [15:0] tcnt;
    logic [15:0] cur_n;
    logic [15:0] next_n;
    logic [7:0]  next_lo;
    logic [7:0]  next_hi;
    logic [7:0]  next_rd;
    logic        wide;
    logic        sync_m;
    logic        fast;
    logic        port_en;
    logic        div_wr;
    logic        cfg_wr;
    logic        clr;
    logic        pre_tick;
    logic        tick_now;
    sbrg_div_t   div_sel;

    // true for either half of the divisor pair
    function automatic logic is_div(input logic [2:0] a);
        return a == `SBRG_ADDR_DLO || a == `SBRG_ADDR_DHI;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // mode decode

    // mode bits straight from the stored control bytes
    assign wide    = baud_w[`SBRG_BIT_WIDE];
    assign sync_m  = txsc_w[`SBRG_BIT_SYNC];
    assign fast    = txsc_w[`SBRG_BIT_FAST];
    assign port_en = rxsc_w[`SBRG_BIT_SPEN];

    // the ratio depends on the speed bit only outside sync mode
    assign div_sel = sbrg_div_select(sync_m, wide, fast);

    // narrow mode never sees the high register, whatever it holds
    assign cur_n = wide ? {div_hi, div_lo} : {8'h00, div_lo};

    // divisor as it stands after a write in this cycle
    assign next_lo = (wr && addr == `SBRG_ADDR_DLO) ? wr_data : div_lo;
    assign next_hi = (wr && addr == `SBRG_ADDR_DHI) ? wr_data : div_hi;
    assign next_n  = wide ? {next_hi, next_lo} : {8'h00, next_lo};

    // strobes; a disabled port holds the timer cleared
    assign div_wr = wr && is_div(addr);
    assign cfg_wr = wr && !is_div(addr);
    assign clr    = div_wr || !port_en;

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    // divisor pair, both halves stored even in narrow mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_lo <= `SBRG_RST_BYTE;
            div_hi <= `SBRG_RST_BYTE;
        end else if (ce) begin
            div_lo <= next_lo;
            div_hi <= next_hi;
        end
    end

    // control bytes keep only their writable bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baud_w <= `SBRG_RST_BYTE;
            rxsc_w <= `SBRG_RST_BYTE;
            txsc_w <= `SBRG_RST_BYTE;
        end else if (ce && cfg_wr) begin
            if (addr == `SBRG_ADDR_BAUD)
                baud_w <= wr_data & `SBRG_MASK_BAUD;
            if (addr == `SBRG_ADDR_RXSC)
                rxsc_w <= wr_data & `SBRG_MASK_RXSC;
            if (addr == `SBRG_ADDR_TXSC)
                txsc_w <= wr_data & `SBRG_MASK_TXSC;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port

    // read mux; status bits merge in at read time, unmapped reads zero
    always_comb begin
        next_rd = 8'h00;
        unique case (addr)
            `SBRG_ADDR_BAUD: begin
                next_rd = baud_w;
                next_rd[`SBRG_BIT_IDLE] = rcv_idle;
            end
            `SBRG_ADDR_RXSC: next_rd = {rxsc_w[7:3], rx_stat.ferr, rx_stat.oerr, rx_stat.rx9d};
            `SBRG_ADDR_DLO:  next_rd = div_lo;
            `SBRG_ADDR_DHI:  next_rd = div_hi;
            `SBRG_ADDR_TXSC: begin
                next_rd = txsc_w;
                next_rd[`SBRG_BIT_TRMT] = tx_shift_empty;
            end
            default:         next_rd = 8'h00;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            rd_data <= 8'h00;
        else if (ce)
            rd_data <= rd ? next_rd : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // rate timer

    // prescaler gives the 4, 16 or 64 clock multiplier
    sbrg_prescale #(
        .CW       (6)
    ) u_pre (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .clr      (clr),
        .sel      (div_sel),
        .pre_tick (pre_tick)
    );

    // a tick ends each n+1 prescaled periods
    assign tick_now = pre_tick && tcnt == 16'h0000;

    // free-running down counter; a divisor write reloads it without
    // waiting for the old period to run out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tcnt <= 16'h0000;
        end else if (ce) begin
            if (clr)
                tcnt <= next_n;
            else if (tick_now)
                tcnt <= cur_n;
            else if (pre_tick)
                tcnt <= tcnt - 16'h0001;
        end
    end

    // tick registered so the output comes from a flip-flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            baud_tick <= 1'b0;
        else if (ce)
            baud_tick <= tick_now;
    end

    // mode bits for the transmitter and receiver, one cycle behind
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            cfg <= '0;
        else if (ce)
            cfg <= '{port_en: port_en, sync_mode: sync_m, wide: wide, high_speed: fast};
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive-idle flag

    // a start bit beats a completion in the same cycle: a new character is under way
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            rcv_idle <= `SBRG_RST_IDLE;
        else if (ce && rx_stat.start)
            rcv_idle <= 1'b0;
        else if (ce && rx_stat.done)
            rcv_idle <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [23:0] per_cnt;
    logic        clean;

    // clocks since the last restart or tick; clean once no mode change has
    // landed inside the running period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            per_cnt <= 24'h000000;
            clean   <= 1'b0;
        end else if (ce) begin
            per_cnt <= (clr || tick_now) ? 24'h000000 : per_cnt + 24'h000001;
            if (cfg_wr)
                clean <= 1'b0;
            else if (clr || tick_now)
                clean <= 1'b1;
        end
    end

    sequence s_div_write;
        ce && div_wr && port_en;
    endsequence

    sequence s_restarted;
        !baud_tick && tcnt == $past(next_n);
    endsequence

    sequence s_slow_tick;
        ce && tick_now && clean && !sync_m && !wide && !fast;
    endsequence

    mode64_period_a: assert property (@(posedge clk) disable iff (rst)
        s_slow_tick |-> div_sel == SBRG_DIV64 &&
            per_cnt == sbrg_period(SBRG_DIV64, cur_n) - 24'h000001)
        else $error("slow async period wrong");

    mode16_period_a: assert property (@(posedge clk) disable iff (rst)
        ce && tick_now && clean && !sync_m && wide && !fast |->
            per_cnt == sbrg_period(SBRG_DIV16, cur_n) - 24'h000001)
        else $error("wide async period wrong");

    sync_period_a: assert property (@(posedge clk) disable iff (rst)
        ce && tick_now && clean && sync_m |->
            per_cnt == sbrg_period(SBRG_DIV4, cur_n) - 24'h000001)
        else $error("sync period wrong");

    fast_period_a: assert property (@(posedge clk) disable iff (rst)
        ce && tick_now && clean && !sync_m && fast |->
            per_cnt == sbrg_period(wide ? SBRG_DIV4 : SBRG_DIV16, cur_n) - 24'h000001)
        else $error("high speed period wrong");

    sync_ignores_fast_a: assert property (@(posedge clk) disable iff (rst)
        sync_m |-> div_sel == SBRG_DIV4)
        else $error("sync ratio follows speed bit");

    write_restart_a: assert property (@(posedge clk) disable iff (rst)
        s_div_write |=> s_restarted)
        else $error("divisor write did not restart timer");

    narrow_low_only_a: assert property (@(posedge clk) disable iff (rst)
        ce && tick_now && !clr && !wide |=> tcnt == {8'h00, $past(div_lo)})
        else $error("narrow reload used high register");

    idle_clear_a: assert property (@(posedge clk) disable iff (rst)
        ce && rx_stat.start |=> !rcv_idle)
        else $error("idle flag not cleared by start");

    idle_set_a: assert property (@(posedge clk) disable iff (rst)
        ce && rx_stat.done && !rx_stat.start |=> rcv_idle)
        else $error("idle flag not set by completion");

    divisor_read_a: assert property (@(posedge clk) disable iff (rst)
        ce && rd && addr == `SBRG_ADDR_DHI |=> rd_data == $past(div_hi))
        else $error("high divisor read wrong");

    tick_pulse_a: assert property (@(posedge clk) disable iff (rst)
        ce && baud_tick && port_en && cur_n != 16'h0000 |=> ce |-> !baud_tick)
        else $error("tick longer than one cycle");

endmodule

// file: sbrg_partner.sv
// stand-in for the serial receiver and transmitter that consume rate ticks
// assumes the block's clk and baud_tick; a go pulse from the bench starts a frame
`timescale 1ns/1ns
module sbrg_partner import sbrg_pkg::*; (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // from block and bench
    input  wire logic baud_tick,
    input  wire logic go,
    // status back to the block
    output sbrg_rxst_t rx_stat,
    output logic       tx_shift_empty
);
    logic [3:0] bits;
    logic       busy;
    ////////////////////////////////////////
    // one frame lasts ten ticks; start and done are one-cycle pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bits <= 4'h0;
            busy <= 1'b0;
            rx_stat <= '0;
        end else begin
            rx_stat <= '0;
            if (go && !busy) begin
                busy <= 1'b1;
                bits <= 4'h0;
                rx_stat.start <= 1'b1;
            end else if (busy && baud_tick) begin
                bits <= bits + 4'h1;
                if (bits == 4'h9) begin
                    busy <= 1'b0;
                    rx_stat.done <= 1'b1;
                end
            end
        end
    end
    // shift register reads full while a frame is on the line
    assign tx_shift_empty = !busy;
endmodule

// file: test_sbrg_top.sv
// self-checking bench of the rate generator: registers, tick periods, idle flag
// assumes one 25 MHz clock; the partner model stands in for receiver and transmitter
`timescale 1ns/1ns
`include "sbrg_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    $display("ERROR %s expected %h seen %h", nm, e, g); n_mismatch++; end end
module test_sbrg_top import sbrg_pkg::*;;
    logic        clk;
    logic        rst;
    logic        ce;
    logic [2:0]  addr;
    logic [7:0]  wr_data;
    logic        wr;
    logic        rd;
    logic [7:0]  rd_data;
    sbrg_rxst_t  rx_stat;
    logic        tx_shift_empty;
    logic        baud_tick;
    sbrg_cfg_t   cfg;
    logic        go;
    logic [31:0] seed;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic        s;
    logic        w;
    logic        f;
    int          n_mismatch = 0;
    int          checks = 0;

    sbrg_top uut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data),
        .wr(wr), .rd(rd), .rd_data(rd_data), .rx_stat(rx_stat),
        .tx_shift_empty(tx_shift_empty), .baud_tick(baud_tick), .cfg(cfg));
    sbrg_partner far (.clk(clk), .rst(rst), .baud_tick(baud_tick), .go(go),
        .rx_stat(rx_stat), .tx_shift_empty(tx_shift_empty));
    ////////////////////////////////////////
    // pseudo-random source, fixed start
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // expected multiplier from mode, width and speed
    function automatic int exp_mult(input logic sm, input logic wm, input logic fm);
        if (sm)
            return 4;
        if (wm)
            return fm ? 4 : 16;
        return fm ? 16 : 64;
    endfunction
    // one-cycle write strobe
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // one-cycle read strobe; data is looked at only in the following cycle
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK("rd_data", e, rd_data)
    endtask
    // latency from a divisor write to the first tick, then one full period
    task automatic meas(input int t);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (baud_tick !== 1'b1 && k < 70000);
        `CHK("first tick", 32'(t), 32'(k))
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (baud_tick !== 1'b1 && k < 70000);
        `CHK("period", 32'(t), 32'(k))
    endtask
    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // watchdog well beyond the longest expected run
    initial begin
        #(90000 * 40);
        n_mismatch++;
        report_and_stop();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        addr = 3'h0;
        wr_data = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        go = 1'b0;
        seed = 32'd69503;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`SBRG_ADDR_BAUD, 8'h40);
        rd_chk(`SBRG_ADDR_TXSC, 8'h02);
        rd_chk(3'h5, 8'h00);
        wr_reg(`SBRG_ADDR_BAUD, 8'hff);
        rd_chk(`SBRG_ADDR_BAUD, 8'h5b);
        $display("test registers done");
        // a frame clears the idle flag until its end
        wr_reg(`SBRG_ADDR_RXSC, 8'h80);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        rd_chk(`SBRG_ADDR_BAUD, 8'h1b);
        rd_chk(`SBRG_ADDR_TXSC, 8'h00);
        repeat (200) @(posedge clk);
        rd_chk(`SBRG_ADDR_BAUD, 8'h5b);
        $display("test receive idle done");
        // every mode combination, divisor partly random, boundaries by hand
        for (int m = 0; m < 8; m++) begin
            seed = lfsr(seed);
            lo = (m == 4) ? 8'h00 : (m == 6) ? 8'hff : {4'h0, seed[3:0]};
            hi = {7'h00, seed[8]};
            s = m[2];
            w = m[1];
            f = m[0];
            wr_reg(`SBRG_ADDR_TXSC, {3'b000, s, 1'b0, f, 2'b00});
            wr_reg(`SBRG_ADDR_BAUD, {4'h0, w, 3'b000});
            wr_reg(`SBRG_ADDR_DHI, hi);
            wr_reg(`SBRG_ADDR_DLO, lo);
            meas(exp_mult(s, w, f) * ((w ? int'(hi) * 256 : 0) + int'(lo) + 1));
            rd_chk(`SBRG_ADDR_DHI, hi);
            `CHK("cfg", {1'b1, s, w, f}, cfg)
            $display("test mode %0d done", m);
        end
        // a write while the clock enable is low is lost
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(`SBRG_ADDR_DLO, 8'haa);
        ce <= 1'b1;
        rd_chk(`SBRG_ADDR_DLO, lo);
        $display("test clock enable done");
        report_and_stop();
    end
endmodule
